// *** hdl/iil_item_rom.sv ***
`timescale 1ns/1ps
module iil_item_rom
	import iil_pkg::*;
#(
	parameter logic [31:0] VENDOR_CODE = 32'h0000_1234, // arbitrary value
	parameter logic [31:0] DEVICE_CODE = 32'h0000_5678, // arbitrary value
	parameter logic [3:0] DESC_MAJOR = 4'h1,
	parameter logic [3:0] DESC_MINOR = 4'h0,
	parameter logic [7:0] DESC_REVISION = 8'h00
) (
	input wire logic [7:0] sel,
	output logic [31:0] item,
	output logic known
);
	// Reserved upper half of the file version reads as zero
	wire [31:0] desc_word = {16'h0000, DESC_MAJOR, DESC_MINOR,
		DESC_REVISION};

	always_comb begin
		item = 32'h0000_0000;
		known = 1'b1;
		unique case (sel)
			IIL_SEL_VENDOR: item = VENDOR_CODE;
			IIL_SEL_DEVICE: item = DEVICE_CODE;
			IIL_SEL_DEV_VERSION: item = IIL_DEV_VERSION_VALUE;
			IIL_SEL_DESC_FILE: item = desc_word;
			IIL_SEL_EXT_ADDR: item = IIL_EXT_ADDR_VALUE;
			default: known = 1'b0;
		endcase
	end
endmodule : iil_item_rom

// *** hdl/iil_lookup.sv ***
`timescale 1ns/1ps
module iil_lookup
	import iil_pkg::*;
#(
	parameter logic [31:0] VENDOR_CODE = 32'h0000_1234, // arbitrary value
	parameter logic [31:0] DEVICE_CODE = 32'h0000_5678, // arbitrary value
	parameter logic [3:0] DESC_MAJOR = 4'h1,
	parameter logic [3:0] DESC_MINOR = 4'h0,
	parameter logic [7:0] DESC_REVISION = 8'h00
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic CMD_VALID,
	input wire logic [7:0] CMD_CODE,
	input wire logic [7:0] ITEM_SELECTOR,
	input wire logic [7:0] READ_OFFSET,
	input wire logic [15:0] READ_SIZE,
	output logic RSP_VALID,
	output logic [7:0] RSP_CODE,
	output logic [7:0] RSP_SELECTOR,
	output logic [7:0] RSP_OFFSET,
	output logic [15:0] RSP_SIZE,
	output logic [8*IIL_RESP_BYTES-1:0] RSP_DATA,
	output logic [7:0] COMMAND_ALARM_CODE
);
	localparam int ITEM_BITS = 8 * IIL_ITEM_BYTES;
	localparam int PAD_BITS = 8 * IIL_RESP_BYTES - ITEM_BITS;

	logic [ITEM_BITS-1:0] item;
	logic known;

	// Offset must name a byte inside the item
	function automatic logic f_offset_ok(input logic [7:0] offset);
		f_offset_ok = offset < 8'(IIL_ITEM_BYTES);
	endfunction : f_offset_ok

	// One bit wider than the wider operand, so the sum never wraps
	function automatic logic [16:0] f_span(input logic [7:0] offset,
		input logic [15:0] size);
		f_span = {9'h000, offset} + {1'b0, size};
	endfunction : f_span

	function automatic logic f_size_zero(input logic [15:0] size);
		f_size_zero = size == 16'h0000;
	endfunction : f_size_zero

	// A read may end on the last byte but not beyond it
	function automatic logic f_size_over(input logic [7:0] offset,
		input logic [15:0] size);
		f_size_over = f_span(offset, size) > 17'(IIL_ITEM_BYTES);
	endfunction : f_size_over

	// Item byte at offset plus lane, or zero once the size is used up
	function automatic logic [7:0] f_lane(
		input logic [ITEM_BITS-1:0] word,
		input logic [7:0] offset,
		input logic [15:0] size,
		input logic [1:0] lane);
		logic [2:0] src;
		logic in_item;
		logic in_size;
		logic [7:0] pick;
		src = {1'b0, offset[1:0]} + {1'b0, lane};
		in_item = src < 3'(IIL_ITEM_BYTES);
		in_size = size > {14'h0000, lane};
		pick = 8'h00;
		if (in_item && in_size) begin
			pick = word[8*src[1:0] +: 8];
		end
		f_lane = pick;
	endfunction : f_lane

	iil_item_rom #(
		.VENDOR_CODE(VENDOR_CODE),
		.DEVICE_CODE(DEVICE_CODE),
		.DESC_MAJOR(DESC_MAJOR),
		.DESC_MINOR(DESC_MINOR),
		.DESC_REVISION(DESC_REVISION)
	) iil_item_rom_i (
		.sel(ITEM_SELECTOR),
		.item(item),
		.known(known)
	);

	// Other codes belong to other handlers and leave every output but RSP_VALID alone
	wire code_match = CMD_CODE == IIL_CMD_READ_IDENTITY;
	wire is_read = CMD_VALID && code_match;

	// Refusal reasons kept apart; any one of them raises the alarm
	wire sel_bad = !known;
	wire offset_bad = !f_offset_ok(READ_OFFSET);
	wire size_zero = f_size_zero(READ_SIZE);
	wire size_over = f_size_over(READ_OFFSET, READ_SIZE);
	wire good = !(sel_bad || offset_bad || size_zero || size_over);

	// Lanes picked one at a time so a short read never leaks upper bytes
	wire [7:0] lane0 = f_lane(item, READ_OFFSET, READ_SIZE, 2'h0);
	wire [7:0] lane1 = f_lane(item, READ_OFFSET, READ_SIZE, 2'h1);
	wire [7:0] lane2 = f_lane(item, READ_OFFSET, READ_SIZE, 2'h2);
	wire [7:0] lane3 = f_lane(item, READ_OFFSET, READ_SIZE, 2'h3);
	wire [ITEM_BITS-1:0] picked = {lane3, lane2, lane1, lane0};

	// Refused reads answer zero data rather than a partial item
	wire [ITEM_BITS-1:0] next_item = good ? picked : '0;
	wire [7:0] next_alarm_value = good ? IIL_ALARM_NONE :
		IIL_ALARM_BAD_PARAM;

	// Echoes, data and alarm hold until the next read, good or refused
	wire next_valid = is_read;
	wire [7:0] next_code = is_read ? CMD_CODE : RSP_CODE;
	wire [7:0] next_selector = is_read ? ITEM_SELECTOR :
		RSP_SELECTOR;
	wire [7:0] next_offset = is_read ? READ_OFFSET : RSP_OFFSET;
	wire [15:0] next_size = is_read ? READ_SIZE : RSP_SIZE;
	wire [8*IIL_RESP_BYTES-1:0] next_data = is_read ?
		{{PAD_BITS{1'b0}}, next_item} : RSP_DATA;
	wire [7:0] next_alarm = is_read ? next_alarm_value :
		COMMAND_ALARM_CODE;

	// Strobe lasts one cycle per read, good or refused
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			RSP_VALID <= 1'b0;
		end else begin
			RSP_VALID <= next_valid;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			RSP_CODE <= IIL_RST_BYTE;
		end else begin
			RSP_CODE <= next_code;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			RSP_SELECTOR <= IIL_RST_BYTE;
		end else begin
			RSP_SELECTOR <= next_selector;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			RSP_OFFSET <= IIL_RST_BYTE;
		end else begin
			RSP_OFFSET <= next_offset;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			RSP_SIZE <= IIL_RST_SIZE;
		end else begin
			RSP_SIZE <= next_size;
		end
	end

	// Upper response bytes stay zero; the item sits in the low word
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			RSP_DATA <= '0;
		end else begin
			RSP_DATA <= next_data;
		end
	end

	// Not sticky: a good read clears an earlier alarm
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			COMMAND_ALARM_CODE <= IIL_ALARM_NONE;
		end else begin
			COMMAND_ALARM_CODE <= next_alarm;
		end
	end
endmodule : iil_lookup

// *** hdl/iil_pkg.sv ***
package iil_pkg;
	localparam logic [7:0] IIL_CMD_READ_IDENTITY = 8'h03;
	localparam logic [7:0] IIL_SEL_VENDOR = 8'h01;
	localparam logic [7:0] IIL_SEL_DEVICE = 8'h02;
	localparam logic [7:0] IIL_SEL_DEV_VERSION = 8'h03;
	localparam logic [7:0] IIL_SEL_DESC_FILE = 8'h04;
	localparam logic [7:0] IIL_SEL_EXT_ADDR = 8'h05;
	localparam logic [7:0] IIL_ALARM_NONE = 8'h00;
	localparam logic [7:0] IIL_ALARM_BAD_PARAM = 8'h09;
	localparam logic [7:0] IIL_RST_BYTE = 8'h00;
	localparam logic [15:0] IIL_RST_SIZE = 16'h0000;
	localparam logic [31:0] IIL_DEV_VERSION_VALUE = 32'h00000000;
	localparam logic [31:0] IIL_EXT_ADDR_VALUE = 32'h00000001;
	localparam int IIL_ITEM_BYTES = 4;
	localparam int IIL_RESP_BYTES = 24;
	localparam int IIL_DESC_REV_LSB = 0;
	localparam int IIL_DESC_MINOR_LSB = 8;
	localparam int IIL_DESC_MAJOR_LSB = 12;
	localparam int IIL_DESC_RSVD_LSB = 16;
endpackage : iil_pkg

// *** sim/iil_lookup_props.sv ***
`timescale 1ns/1ps
module iil_lookup_props (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic CMD_VALID,
	input wire logic RSP_VALID,
	input wire logic [7:0] CMD_CODE,
	input wire logic [7:0] ITEM_SELECTOR,
	input wire logic [7:0] READ_OFFSET,
	input wire logic [7:0] RSP_SELECTOR,
	input wire logic [7:0] COMMAND_ALARM_CODE,
	input wire logic [15:0] READ_SIZE,
	input wire logic [191:0] RSP_DATA
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	wire tk = CMD_VALID && CMD_CODE == 8'h03;
	wire bad = ITEM_SELECTOR - 8'h01 > 8'h04 || READ_OFFSET > 8'h03
		|| READ_SIZE == 16'h0 || READ_SIZE > 16'h4 - READ_OFFSET;
	sequence s_ok; tk && !bad; endsequence
	a_rsp_pulse: assert property (tk |=> RSP_VALID)
		else $error("no rsp");
	a_no_stray: assert property (!tk |=> !RSP_VALID)
		else $error("stray");
	a_sel_echo: assert property (tk |=>
		RSP_SELECTOR == $past(ITEM_SELECTOR)) else $error("echo");
	a_echo_hold: assert property (!tk |=>
		$stable(RSP_SELECTOR) && $stable(COMMAND_ALARM_CODE))
		else $error("hold");
	a_bad_alarm: assert property (tk && bad |=>
		COMMAND_ALARM_CODE == 8'h09 && RSP_DATA == '0) else $error("bad");
	a_ok_alarm: assert property (s_ok |=> COMMAND_ALARM_CODE == 8'h00)
		else $error("ok");
	a_ver_zero: assert property (s_ok ##0 ITEM_SELECTOR == 8'h03
		|=> RSP_DATA == '0) else $error("ver");
	a_ext_one: assert property (s_ok ##0 ITEM_SELECTOR == 8'h05
		&& READ_OFFSET == 8'h00 |=> RSP_DATA == 192'h1) else $error("ext");
	a_rsvd_zero: assert property (s_ok ##0 ITEM_SELECTOR == 8'h04
		|=> RSP_DATA[191:16] == '0) else $error("rsvd");
	a_size_cap: assert property (s_ok |=>
		(RSP_DATA >> (8 * $past(READ_SIZE))) == '0) else $error("size");
endmodule : iil_lookup_props
bind iil_lookup iil_lookup_props iil_lookup_props_i (.*);

// *** sim/iil_lookup_tb_top.sv ***
`timescale 1ns/1ps
module iil_lookup_tb_top;
	logic CLK_SYS = 0, RST = 1, v, rv;
	logic [7:0] c, s, o, rc, rs, ro, al;
	logic [15:0] z, rz;
	logic [191:0] d;
	int n_mismatch = 0, check_count = 0;
	initial forever #2.5 CLK_SYS = ~CLK_SYS;
	iil_master iil_master_i (.clk(CLK_SYS), .v, .c, .s, .o, .z);
	iil_lookup iil_lookup_i (.CLK_SYS, .RST, .CMD_VALID(v), .CMD_CODE(c),
		.ITEM_SELECTOR(s), .READ_OFFSET(o), .READ_SIZE(z), .RSP_VALID(rv),
		.RSP_CODE(rc), .RSP_SELECTOR(rs), .RSP_OFFSET(ro), .RSP_SIZE(rz),
		.RSP_DATA(d), .COMMAND_ALARM_CODE(al));
	task automatic chk(string n, logic [191:0] e, g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %0h got %0h", n, e, g);
		end
	endtask : chk
	task automatic rq(logic [7:0] a, b, logic [15:0] n,
		logic [31:0] e, logic [7:0] m);
		iil_master_i.rd(8'h03, a, b, n);
		chk("echo", {151'h0, 1'b1, 8'h03, a, b, n},
			{151'h0, rv, rc, rs, ro, rz});
		chk("data", {160'h0, e}, d);
		chk("alarm", {184'h0, m}, {184'h0, al});
	endtask : rq
	task automatic t_items;
		rq(8'h01, 8'h00, 16'h0004, 32'h0000_1234, 8'h00);
		rq(8'h02, 8'h00, 16'h0004, 32'h0000_5678, 8'h00);
		rq(8'h03, 8'h00, 16'h0004, 32'h0000_0000, 8'h00);
		rq(8'h04, 8'h00, 16'h0004, 32'h0000_1000, 8'h00);
		rq(8'h05, 8'h00, 16'h0004, 32'h0000_0001, 8'h00);
	endtask : t_items
	task automatic t_bad;
		rq(8'h00, 8'h00, 16'h0004, 32'h0000_0000, 8'h09);
		rq(8'h06, 8'h00, 16'h0004, 32'h0000_0000, 8'h09);
		rq(8'h01, 8'h04, 16'h0001, 32'h0000_0000, 8'h09);
		rq(8'h01, 8'h00, 16'h0000, 32'h0000_0000, 8'h09);
		rq(8'h01, 8'h02, 16'h0003, 32'h0000_0000, 8'h09);
	endtask : t_bad
	task automatic t_part;
		rq(8'h02, 8'h01, 16'h0002, 32'h0000_0056, 8'h00);
		rq(8'h01, 8'h01, 16'h0003, 32'h0000_0012, 8'h00);
		rq(8'h04, 8'h01, 16'h0001, 32'h0000_0010, 8'h00);
		rq(8'h01, 8'h00, 16'h0001, 32'h0000_0034, 8'h00);
		rq(8'h02, 8'h00, 16'h0001, 32'h0000_0078, 8'h00);
		iil_master_i.rd(8'h04, 8'h01, 8'h03, 16'h0004);
		chk("ignored", 192'h0, {191'h0, rv});
		chk("held", {176'h0, 8'h02, 8'h00}, {176'h0, rs, ro});
	endtask : t_part
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	initial begin
		repeat (3) @(negedge CLK_SYS);
		RST = 0;
		t_items;
		t_bad;
		t_part;
		complete_run;
	end
endmodule : iil_lookup_tb_top

// *** sim/iil_master.sv ***
`timescale 1ns/1ps
module iil_master (
	input wire logic clk,
	output logic v,
	output logic [7:0] c,
	output logic [7:0] s,
	output logic [7:0] o,
	output logic [15:0] z
);
	initial {v, c, s, o, z} = '0;
	task automatic rd(logic [7:0] k, a, b, logic [15:0] n);
		@(negedge clk) {v, c, s, o, z} = {1'b1, k, a, b, n};
		// Released selector inverted so a stale value never passes
		@(negedge clk) {v, s} = {1'b0, ~a};
	endtask : rd
endmodule : iil_master
